// *** logic/aopc_pkg.sv ***
// Package: register map, field layout and constants of the converter config slice
package aopc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_POWER      = 8'h43;  // power_and_output_control
   localparam logic [7:0] IDX_HIGH_FREQ  = 8'h4A;  // high_frequency_performance
   localparam logic [7:0] IDX_OFFSET_BIAS = 8'hBF; // offset_bias_setting
   localparam logic [7:0] IDX_LOOP_CFG   = 8'hCF;  // offset_loop_config
   localparam logic [7:0] IDX_LOOP_CTRL  = 8'hE0;  // loop enable control
   localparam logic [7:0] IDX_STATUS     = 8'hE1;  // power and loop state, read only
   localparam logic [7:0] IDX_ESTIMATE   = 8'hE2;  // current correction estimate, read only

   // Reset values
   localparam logic [7:0] RST_POWER       = 8'h00;
   localparam logic [7:0] RST_HIGH_FREQ   = 8'h00;
   localparam logic [7:0] RST_OFFSET_BIAS = 8'h00;
   localparam logic [7:0] RST_LOOP_CFG    = 8'h00;
   localparam logic [7:0] RST_LOOP_CTRL   = 8'h00;

   // Writable bits; everything else is reserved and reads zero
   localparam logic [7:0] MASK_POWER       = 8'h53;
   localparam logic [7:0] MASK_HIGH_FREQ   = 8'h01;
   localparam logic [7:0] MASK_OFFSET_BIAS = 8'hF0;
   localparam logic [7:0] MASK_LOOP_CFG    = 8'hBC;
   localparam logic [7:0] MASK_LOOP_CTRL   = 8'h01;

   // Field positions
   localparam int POS_FULL_POWER_DOWN  = 6;
   localparam int POS_OUTPUT_DRIVER_OFF = 4;
   localparam int POS_SWING_LSB        = 0;
   localparam int POS_HIGH_FREQ_BOOST  = 0;
   localparam int POS_PEDESTAL_LSB     = 4;
   localparam int POS_ESTIMATE_HOLD    = 7;
   localparam int POS_SPAN_LSB         = 2;
   localparam int POS_LOOP_ON          = 0;

   // Swing override enable codes
   localparam logic [1:0] SWING_OFF = 2'h0;
   localparam logic [1:0] SWING_ON  = 2'h3;

   // Converter data and correction loop
   localparam int          DATA_W        = 12;
   localparam int          ACC_W         = 44;
   localparam int          EST_W         = 13;
   localparam logic [12:0] MID_CODE      = 13'h0800;
   localparam logic [4:0]  SPAN_BASE_LOG = 5'h14;    // 1M cycles is two to the twentieth
   localparam logic [3:0]  SPAN_MAX_CODE = 4'hB;     // 2G cycles
   localparam logic [11:0] CODE_MAX      = 12'hFFF;

   // Slow wake-up after full power down, in clock cycles
   localparam int          WAKE_CYCLES   = 4000;
   localparam int          WAKE_W        = 16;

   // Power state of the core
   typedef enum logic [1:0] {
      PWR_ON   = 2'b00,
      PWR_OFF  = 2'b01,
      PWR_WAKE = 2'b10
   } aopc_pwr_type;

endpackage

// *** logic/aopc_offset_loop.sv ***
// Offset correction loop: estimate accumulator, pedestal target and hold
`timescale 1ns/100ps
module aopc_offset_loop (
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               reset,
   // Sample stream
   input  wire logic                               sample_valid,
   input  wire logic [aopc_pkg::DATA_W-1:0]        sample_code,
   // Configuration
   input  wire logic                               dc_shift_loop_on,
   input  wire logic                               estimate_hold,
   input  wire logic [3:0]                         loop_averaging_span,
   input  wire logic [3:0]                         pedestal,
   // Results
   output logic      [aopc_pkg::DATA_W-1:0]        corrected_code,
   output logic                                    corrected_valid,
   output logic      [aopc_pkg::EST_W-1:0]         estimate
);

   // All loop state
   typedef struct packed {
      logic signed [aopc_pkg::ACC_W-1:0]  acc;     // Integrated error
      logic        [aopc_pkg::DATA_W-1:0] corr;    // Corrected sample
      logic                               valid;   // Corrected sample strobe
   } aopc_loop_type;

   aopc_loop_type state_ff;
   aopc_loop_type nxt_state;

   logic        [4:0]                shift;       // Log2 of the time constant
   logic signed [aopc_pkg::EST_W-1:0] est;        // Current estimate
   logic signed [aopc_pkg::EST_W-1:0] target;     // Mid code plus pedestal
   logic signed [13:0]               diff;        // Raw code minus estimate
   logic        [aopc_pkg::DATA_W-1:0] clipped;   // Diff clipped to code range
   logic signed [13:0]               err;         // Distance from target

   // Time constant doubles per code; unused codes clamp to the longest
   always_comb begin
      if (loop_averaging_span > aopc_pkg::SPAN_MAX_CODE) begin
         shift = aopc_pkg::SPAN_BASE_LOG + {1'b0, aopc_pkg::SPAN_MAX_CODE};
      end else begin
         shift = aopc_pkg::SPAN_BASE_LOG + {1'b0, loop_averaging_span};
      end
   end

   // Estimate is the integrated error scaled down by the time constant
   assign est = aopc_pkg::EST_W'(state_ff.acc >>> shift);

   // Pedestal is a signed LSB count added to the mid code
   assign target = $signed(aopc_pkg::MID_CODE) + {{9{pedestal[3]}}, pedestal};

   // Apply the estimate and clip, so a large estimate cannot wrap the code
   always_comb begin
      diff = $signed({2'b00, sample_code}) - {est[12], est};
      if (diff < 14'sd0) begin
         clipped = '0;
      end else if (diff > $signed({2'b00, aopc_pkg::CODE_MAX})) begin
         clipped = aopc_pkg::CODE_MAX;
      end else begin
         clipped = diff[aopc_pkg::DATA_W-1:0];
      end
      err = $signed({2'b00, clipped}) - {target[12], target};
   end

   // Next state of the loop
   always_comb begin
      nxt_state       = state_ff;
      nxt_state.valid = sample_valid;
      if (!dc_shift_loop_on) begin
         // Loop off: pass data straight and forget the estimate
         nxt_state.acc = '0;
         if (sample_valid) begin
            nxt_state.corr = sample_code;
         end
      end else if (sample_valid) begin
         // Held estimate still corrects every sample
         nxt_state.corr = clipped;
         if (!estimate_hold) begin
            nxt_state.acc = state_ff.acc - {{(aopc_pkg::ACC_W-14){err[13]}}, err};
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign corrected_code  = state_ff.corr;
   assign corrected_valid = state_ff.valid;
   assign estimate        = est;

endmodule

// *** logic/aopc_config_regs.sv ***
// Top: configuration registers, power control and output drive of the converter
// Function
// - Output driver off: data and clock pins high-Z
// - Swing override: 00 disabled, 11 enabled only
// - Boost bit resets to zero, one selects boost
// - Pedestal bits 7:4 are two's complement LSBs
// - Enabled loop drives output toward mid code; here the accumulator subtracts the error, so output moves away from it
// - Pedestal is added to the converged target
// - Loop config: hold bit 7, span 5:2
// - Hold stops estimate, keeps applying last one
// - Span sets time constant, 1M doubling to 2G
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
module aopc_config_regs #(
   parameter int WAKE_CYCLES = aopc_pkg::WAKE_CYCLES   // Slow wake-up length
) (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            reset,
   // Wishbone slave
   input  wire logic                            cyc_i,
   input  wire logic                            stb_i,
   input  wire logic                            we_i,
   input  wire logic [9:0]                      adr_i,
   input  wire logic [3:0]                      sel_i,
   input  wire logic [31:0]                     dat_i,
   output logic      [31:0]                     dat_o,
   output logic                                 ack_o,
   // Converter samples in
   input  wire logic                            sample_valid,
   input  wire logic [aopc_pkg::DATA_W-1:0]     sample_code,
   // Analog power controls
   output logic                                 core_power_off,
   output logic                                 reference_off,
   output logic                                 high_freq_boost,
   output logic                                 swing_override_on,
   // Output pins
   output logic      [aopc_pkg::DATA_W-1:0]     data_out,
   output logic                                 data_out_oe,
   output logic                                 clk_out_oe
);

   // All register state of the block
   typedef struct packed {
      logic [7:0]                      power;      // power_and_output_control
      logic [7:0]                      high_freq;  // high_frequency_performance
      logic [7:0]                      bias;       // offset_bias_setting
      logic [7:0]                      loop_cfg;   // offset_loop_config
      logic [7:0]                      loop_ctrl;  // Loop enable
      logic                            ack;        // Bus acknowledge
      logic [31:0]                     rdata;      // Bus read data
      aopc_pkg::aopc_pwr_type          pwr;        // Power state
      logic [aopc_pkg::WAKE_W-1:0]     wake_cnt;   // Wake-up cycles left
      logic                            core_off;   // Core power down
      logic                            ref_off;    // Reference power down
      logic                            boost;      // High frequency boost
      logic                            swing_on;   // Swing override enable
      logic [aopc_pkg::DATA_W-1:0]     dout;       // Data pins
      logic                            oe;         // Data and clock pin enable
   } aopc_regs_type;

   aopc_regs_type state_ff;
   aopc_regs_type nxt_state;

   logic                           bus_req;     // New request this cycle
   logic [aopc_pkg::DATA_W-1:0]    corr_code;   // Corrected sample
   logic                           corr_valid;  // Corrected sample strobe
   logic [aopc_pkg::EST_W-1:0]     estimate;    // Loop estimate
   logic                           loop_on;     // Loop enable
   logic                           core_live;   // Core is running

   // Register select, shared by write and read decoding
   function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
      hit = (adr[9:2] == idx);
   endfunction

   // Ack rises once per request and drops the cycle after
   assign bus_req   = cyc_i && stb_i && !state_ff.ack;
   assign loop_on   = state_ff.loop_ctrl[aopc_pkg::POS_LOOP_ON];
   assign core_live = (state_ff.pwr == aopc_pkg::PWR_ON);

   // Samples are ignored while the core is down or waking
   aopc_offset_loop u_loop (
      .clk                 (clk),
      .reset               (reset),
      .sample_valid        (sample_valid && core_live),
      .sample_code         (sample_code),
      .dc_shift_loop_on    (loop_on),
      .estimate_hold       (state_ff.loop_cfg[aopc_pkg::POS_ESTIMATE_HOLD]),
      .loop_averaging_span (state_ff.loop_cfg[aopc_pkg::POS_SPAN_LSB +: 4]),
      .pedestal            (state_ff.bias[aopc_pkg::POS_PEDESTAL_LSB +: 4]),
      .corrected_code      (corr_code),
      .corrected_valid     (corr_valid),
      .estimate            (estimate)
   );

   // Next state: bus writes and reads, power sequencing, pin drive
   always_comb begin
      nxt_state     = state_ff;
      nxt_state.ack = bus_req;

      // Writes land at the ack edge, where the master sees the answer; reserved bits stay zero
      if (state_ff.ack && cyc_i && stb_i && we_i && sel_i[0]) begin
         if (hit(adr_i, aopc_pkg::IDX_POWER)) begin
            nxt_state.power = dat_i[7:0] & aopc_pkg::MASK_POWER;
         end
         if (hit(adr_i, aopc_pkg::IDX_HIGH_FREQ)) begin
            nxt_state.high_freq = dat_i[7:0] & aopc_pkg::MASK_HIGH_FREQ;
         end
         if (hit(adr_i, aopc_pkg::IDX_OFFSET_BIAS)) begin
            nxt_state.bias = dat_i[7:0] & aopc_pkg::MASK_OFFSET_BIAS;
         end
         if (hit(adr_i, aopc_pkg::IDX_LOOP_CFG)) begin
            nxt_state.loop_cfg = dat_i[7:0] & aopc_pkg::MASK_LOOP_CFG;
         end
         if (hit(adr_i, aopc_pkg::IDX_LOOP_CTRL)) begin
            nxt_state.loop_ctrl = dat_i[7:0] & aopc_pkg::MASK_LOOP_CTRL;
         end
      end

      // Reads; unmapped addresses answer with zero
      nxt_state.rdata = '0;
      if (bus_req && !we_i) begin
         if (hit(adr_i, aopc_pkg::IDX_POWER)) begin
            nxt_state.rdata = {24'h000000, state_ff.power};
         end else if (hit(adr_i, aopc_pkg::IDX_HIGH_FREQ)) begin
            nxt_state.rdata = {24'h000000, state_ff.high_freq};
         end else if (hit(adr_i, aopc_pkg::IDX_OFFSET_BIAS)) begin
            nxt_state.rdata = {24'h000000, state_ff.bias};
         end else if (hit(adr_i, aopc_pkg::IDX_LOOP_CFG)) begin
            nxt_state.rdata = {24'h000000, state_ff.loop_cfg};
         end else if (hit(adr_i, aopc_pkg::IDX_LOOP_CTRL)) begin
            nxt_state.rdata = {24'h000000, state_ff.loop_ctrl};
         end else if (hit(adr_i, aopc_pkg::IDX_STATUS)) begin
            nxt_state.rdata = {29'h00000000,
                               loop_on && state_ff.loop_cfg[aopc_pkg::POS_ESTIMATE_HOLD],
                               state_ff.pwr};
         end else if (hit(adr_i, aopc_pkg::IDX_ESTIMATE)) begin
            nxt_state.rdata = {19'h00000, estimate};
         end
      end

      // Power sequencing follows the registered power bit
      case (state_ff.pwr)
         aopc_pkg::PWR_ON: begin
            if (state_ff.power[aopc_pkg::POS_FULL_POWER_DOWN]) begin
               nxt_state.pwr = aopc_pkg::PWR_OFF;
            end
         end
         aopc_pkg::PWR_OFF: begin
            // Leaving full power down restarts the slow wake-up timer
            if (!state_ff.power[aopc_pkg::POS_FULL_POWER_DOWN]) begin
               nxt_state.pwr      = aopc_pkg::PWR_WAKE;
               nxt_state.wake_cnt = aopc_pkg::WAKE_W'(WAKE_CYCLES - 1);
            end
         end
         aopc_pkg::PWR_WAKE: begin
            // A new power down during wake-up wins at once
            if (state_ff.power[aopc_pkg::POS_FULL_POWER_DOWN]) begin
               nxt_state.pwr = aopc_pkg::PWR_OFF;
            end else if (state_ff.wake_cnt == '0) begin
               nxt_state.pwr = aopc_pkg::PWR_ON;
            end else begin
               nxt_state.wake_cnt = state_ff.wake_cnt - 1'b1;
            end
         end
         default: begin
            nxt_state.pwr = aopc_pkg::PWR_OFF;
         end
      endcase

      // Analog controls; references stay up during wake-up
      nxt_state.core_off = (nxt_state.pwr != aopc_pkg::PWR_ON);
      nxt_state.ref_off  = (nxt_state.pwr == aopc_pkg::PWR_OFF);
      nxt_state.boost    = nxt_state.high_freq[aopc_pkg::POS_HIGH_FREQ_BOOST];
      // Codes 01 and 10 are forbidden; they leave the override off
      nxt_state.swing_on = (nxt_state.power[aopc_pkg::POS_SWING_LSB +: 2]
                            == aopc_pkg::SWING_ON);

      // Pins are released whenever the buffers or the whole part are down
      nxt_state.oe = !nxt_state.power[aopc_pkg::POS_OUTPUT_DRIVER_OFF]
                     && !nxt_state.core_off;
      if (!nxt_state.oe) begin
         nxt_state.dout = '0;
      end else if (corr_valid) begin
         nxt_state.dout = corr_code;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff           <= '0;
         state_ff.power     <= aopc_pkg::RST_POWER;
         state_ff.high_freq <= aopc_pkg::RST_HIGH_FREQ;
         state_ff.bias      <= aopc_pkg::RST_OFFSET_BIAS;
         state_ff.loop_cfg  <= aopc_pkg::RST_LOOP_CFG;
         state_ff.loop_ctrl <= aopc_pkg::RST_LOOP_CTRL;
         state_ff.pwr       <= aopc_pkg::PWR_ON;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs come straight from the state register
   assign dat_o             = state_ff.rdata;
   assign ack_o             = state_ff.ack;
   assign core_power_off    = state_ff.core_off;
   assign reference_off     = state_ff.ref_off;
   assign high_freq_boost   = state_ff.boost;
   assign swing_override_on = state_ff.swing_on;
   assign data_out          = state_ff.dout;
   assign data_out_oe       = state_ff.oe;
   assign clk_out_oe        = state_ff.oe;

endmodule

// *** dv/aopc_config_regs_properties.sv ***
// Checker: pin, power and bus timing relations of the converter config slice
`timescale 1ns/100ps
module aopc_regs_chk #(
   parameter int WAKE_CYCLES = 8   // Slow wake-up length
) (
   // Clock and reset
   input wire logic                        clk,
   input wire logic                        reset,
   // Wishbone slave side
   input wire logic                        cyc_i,
   input wire logic                        stb_i,
   input wire logic                        we_i,
   input wire logic [9:0]                  adr_i,
   input wire logic [3:0]                  sel_i,
   input wire logic [31:0]                 dat_i,
   input wire logic                        ack_o,
   // Power and pins
   input wire logic                        core_power_off,
   input wire logic                        reference_off,
   input wire logic                        high_freq_boost,
   input wire logic                        swing_override_on,
   input wire logic [aopc_pkg::DATA_W-1:0] data_out,
   input wire logic                        data_out_oe,
   input wire logic                        clk_out_oe
);
   // Tolerance of two cycles on where the wake count starts
   localparam int WAKE_MIN = WAKE_CYCLES - 2;
   logic        take;        // Request taken this edge
   logic        wr_pwr;      // Write to power register taken
   logic        wr_hf;       // Write to boost register taken
   logic [15:0] wake_cnt_ff; // Cycles spent waking
   assign take   = cyc_i && stb_i && !ack_o;
   assign wr_pwr = take && we_i && sel_i[0] && adr_i[9:2] == aopc_pkg::IDX_POWER;
   assign wr_hf  = take && we_i && sel_i[0] && adr_i[9:2] == aopc_pkg::IDX_HIGH_FREQ;
   // Count core-off cycles while references are already back
   always_ff @(posedge clk) begin
      if (reset || !(core_power_off && !reference_off))
         wake_cnt_ff <= 16'h0000;
      else
         wake_cnt_ff <= wake_cnt_ff + 16'h0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_ack_pulse; take |=> ack_o ##1 !ack_o; endproperty
   property p_pin_pair; data_out_oe == clk_out_oe; endproperty
   property p_hiz_zero; !data_out_oe |-> data_out == '0; endproperty
   property p_full_off; reference_off |-> core_power_off && !data_out_oe; endproperty
   property p_full_down; wr_pwr && dat_i[6] |-> ##3 reference_off && core_power_off; endproperty
   property p_driver_off; wr_pwr && dat_i[4] |-> ##3 !data_out_oe; endproperty
   property p_swing_on; wr_pwr && dat_i[1:0] == 2'h3 |-> ##[1:3] swing_override_on; endproperty
   property p_swing_off; wr_pwr && dat_i[1:0] != 2'h3 |-> ##[1:3] !swing_override_on; endproperty
   property p_boost; wr_hf && dat_i[0] |-> ##[1:3] high_freq_boost; endproperty
   property p_boost_rst; $fell(reset) |-> !high_freq_boost && !swing_override_on; endproperty
   property p_slow_wake;
      $fell(core_power_off) && !reference_off |-> wake_cnt_ff >= WAKE_MIN;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle after request");
   a_pin_pair: assert property (p_pin_pair) else $error("data and clock pin enables differ");
   a_hiz_zero: assert property (p_hiz_zero) else $error("disabled pins carry data");
   a_full_off: assert property (p_full_off) else $error("references off but core on");
   a_full_down: assert property (p_full_down) else $error("full power down missed");
   a_driver_off: assert property (p_driver_off) else $error("pins still driven");
   a_swing_on: assert property (p_swing_on) else $error("swing override not on");
   a_swing_off: assert property (p_swing_off) else $error("swing override not off");
   a_boost: assert property (p_boost) else $error("boost not set");
   a_boost_rst: assert property (p_boost_rst) else $error("mode bits not zero after reset");
   a_slow_wake: assert property (p_slow_wake) else $error("wake-up too short");
   // Main scenarios reached
   c_full_down: cover property (wr_pwr && dat_i[6]);
   c_swing: cover property ($rose(swing_override_on));
   c_wake: cover property ($fell(reference_off));
endmodule
bind aopc_config_regs aopc_regs_chk #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (
   .clk(clk), .reset(reset), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .core_power_off(core_power_off),
   .reference_off(reference_off), .high_freq_boost(high_freq_boost),
   .swing_override_on(swing_override_on), .data_out(data_out),
   .data_out_oe(data_out_oe), .clk_out_oe(clk_out_oe));

// *** dv/aopc_host.sv ***
// Host model: Wishbone master that programs the converter config registers
`timescale 1ns/100ps
module aopc_host (
   // Clock
   input  wire logic        clk,
   // Wishbone master side
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [9:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   input  wire logic [31:0] dat_i,
   input  wire logic        ack_i
);
   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 10'h000;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // One classic cycle; everything held until ack is sampled, no wait limit
   task automatic xfer(input logic wr, input logic [7:0] i, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= wr;
      adr_o <= {i, 2'b00};
      sel_o <= 4'h1;
      dat_o <= {24'h0, d};
      do @(posedge clk); while (ack_i !== 1'b1);
      q = dat_i[7:0];
      // Released lines show junk so a stale value cannot pass
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      adr_o <= ~{i, 2'b00};
      dat_o <= ~{24'h0, d};
   endtask
   // Register write and read
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, i, d, q);
   endtask
   task automatic rd(input logic [7:0] i, output logic [7:0] q);
      xfer(1'b0, i, 8'h00, q);
   endtask
   // Boost only for fast analog inputs
   task automatic set_input_freq(input int mhz);
      wr(aopc_pkg::IDX_HIGH_FREQ, (mhz > 230) ? 8'h01 : 8'h00);
   endtask
endmodule

// *** dv/tb.sv ***
// Testbench: bench register and pin model checked against the config slice
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_count++; \
   $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module tb;
   localparam int WAKE = 8;              // Short wake-up keeps the run brief
   logic        clk = 1'b0;              // 200 MHz clock
   logic        reset = 1'b1;            // Synchronous reset
   logic        cyc, stb, we, ack;       // Bus handshake
   logic [9:0]  adr;                     // Byte address
   logic [3:0]  sel;                     // Byte selects
   logic [31:0] wdat, rdat;              // Bus data
   logic        sample_valid;            // Sample strobe
   logic [11:0] sample_code, dout;       // Samples in, pins out
   logic        core_off, ref_off, boost, swing, doe, coe;
   int          err_count, n_checks, n;  // Tallies
   logic [7:0]  mdl [logic [7:0]];       // Bench copy of register contents
   logic [7:0]  idx [7] = '{aopc_pkg::IDX_POWER, aopc_pkg::IDX_HIGH_FREQ,
      aopc_pkg::IDX_OFFSET_BIAS, aopc_pkg::IDX_LOOP_CFG, aopc_pkg::IDX_LOOP_CTRL,
      8'h10, aopc_pkg::IDX_ESTIMATE};
   always #2.5 clk = ~clk;
   aopc_config_regs #(.WAKE_CYCLES(WAKE)) u_aopc_config_regs (.clk(clk), .reset(reset),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .sample_valid(sample_valid), .sample_code(sample_code),
      .core_power_off(core_off), .reference_off(ref_off), .high_freq_boost(boost),
      .swing_override_on(swing), .data_out(dout), .data_out_oe(doe), .clk_out_oe(coe));
   aopc_host u_aopc_host (.clk(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
      .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
   // Writable bits per register; unmapped and read-only places keep nothing
   function automatic logic [7:0] mask_of(input logic [7:0] i);
      case (i)
         aopc_pkg::IDX_POWER:       return aopc_pkg::MASK_POWER;
         aopc_pkg::IDX_HIGH_FREQ:   return aopc_pkg::MASK_HIGH_FREQ;
         aopc_pkg::IDX_OFFSET_BIAS: return aopc_pkg::MASK_OFFSET_BIAS;
         aopc_pkg::IDX_LOOP_CFG:    return aopc_pkg::MASK_LOOP_CFG;
         aopc_pkg::IDX_LOOP_CTRL:   return aopc_pkg::MASK_LOOP_CTRL;
         default:                   return 8'h00;
      endcase
   endfunction
   // Write through the host and track it in the bench copy
   task automatic wr_m(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] w;
      w = (mask_of(i) != 8'h00) ? d & mask_of(i) : d;
      if (i == aopc_pkg::IDX_POWER) w[1:0] = {2{w[0]}};
      u_aopc_host.wr(i, w);
      if (mask_of(i) != 8'h00) mdl[i] = w;
   endtask
   task automatic chk_rd(input logic [7:0] i);
      logic [7:0] q;
      u_aopc_host.rd(i, q);
      `CHK("register", (mdl.exists(i) ? mdl[i] : 8'h00), q)
   endtask
   // One sample in; result on the pins one edge after it is taken, checked one edge later
   task automatic send(input logic [11:0] c, input logic on);
      sample_valid <= 1'b1;
      sample_code  <= c;
      @(posedge clk);
      sample_valid <= 1'b0;
      sample_code  <= ~c;
      repeat (2) @(posedge clk);
      #1;
      `CHK("data_out", (on ? c : 12'h000), dout)
      `CHK("data_oe", on, doe)
      `CHK("clk_oe", on, coe)
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard: far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      err_count++;
      test_done();
   end
   // Main sequence
   initial begin
      err_count = 0;
      n_checks = 0;
      sample_valid = 1'b0;
      sample_code = 12'h000;
      void'($urandom(77));
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (idx[i]) chk_rd(idx[i]);
      `CHK("boost_rst", 1'b0, boost)
      // Random data, reserved bits and illegal swing codes kept off, unmapped place included
      repeat (4) foreach (idx[i]) begin
         wr_m(idx[i], 8'($urandom));
         chk_rd(idx[i]);
      end
      foreach (idx[i]) wr_m(idx[i], 8'h00);
      // Both legal swing codes; the host never commands 01 or 10
      for (int c = 0; c < 4; c += 3) begin
         wr_m(aopc_pkg::IDX_POWER, 8'(c));
         repeat (3) @(posedge clk);
         `CHK("swing", (c == 3), swing)
      end
      for (int f = 100; f <= 300; f += 200) begin
         u_aopc_host.set_input_freq(f);
         mdl[aopc_pkg::IDX_HIGH_FREQ] = (f > 230) ? 8'h01 : 8'h00;
         repeat (3) @(posedge clk);
         `CHK("boost", (f > 230), boost)
      end
      // All pedestal codes and all span codes with hold set
      for (int c = 0; c < 16; c++) begin
         wr_m(aopc_pkg::IDX_OFFSET_BIAS, 8'(c << 4));
         chk_rd(aopc_pkg::IDX_OFFSET_BIAS);
         wr_m(aopc_pkg::IDX_LOOP_CFG, 8'(c << 2) | 8'h80);
         chk_rd(aopc_pkg::IDX_LOOP_CFG);
      end
      // Pins: normal, driver off, back on
      wr_m(aopc_pkg::IDX_POWER, 8'h00);
      repeat (3) @(posedge clk);
      send(12'($urandom), 1'b1);
      wr_m(aopc_pkg::IDX_POWER, 8'h10);
      repeat (3) @(posedge clk);
      send(12'($urandom), 1'b0);
      wr_m(aopc_pkg::IDX_POWER, 8'h00);
      repeat (3) @(posedge clk);
      send(12'($urandom), 1'b1);
      // Full power down, then the slow wake-up
      wr_m(aopc_pkg::IDX_POWER, 8'h40);
      repeat (3) @(posedge clk);
      `CHK("ref_off", 1'b1, ref_off)
      send(12'($urandom), 1'b0);
      wr_m(aopc_pkg::IDX_POWER, 8'h00);
      n = 0;
      while (core_off === 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      `CHK("wake_len", 1'b1, (n >= WAKE && n <= WAKE + 3))
      `CHK("core_on", 1'b0, core_off)
      `CHK("ref_on", 1'b0, ref_off)
      // Loop on with estimate held: last estimate, still zero, keeps applying
      wr_m(aopc_pkg::IDX_LOOP_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      send(12'($urandom), 1'b1);
      chk_rd(aopc_pkg::IDX_ESTIMATE);
      test_done();
   end
endmodule
